/* design/fjsm_monitor.sv */
// finisher jam watch, stapler checks, priming and staple level count
// Contract
// - jam when paper present at check instant
// - any jam halts operation, notifies host; staple jam here only notifies, stapler back to idle, no halt
// - no leading edge before timeout: feed-delay jam
// - no trailing edge before timeout: feed-stationary jam
// - delivery trailing edge late: delivery-stationary jam
// - inlet paper during initial drive: residual jam
// - no high-low-high home pattern: stapler failure, halt
// - fell only: reverse once, rise means staple jam
// - presence low then high starts self-priming
// - priming repeats staple ops while ready high
// - eleven priming ops still high: priming failure
// - presence low: twenty left, low-staple warning
// - twenty more ops: cartridge empty notice
// - host start-up first, then standby, commands only
// - jogger clockwise opens, counter-clockwise closes
`timescale 1ns/1ps
`default_nettype none
`include "fjsm_params.svh"

module fjsm_monitor #(
  parameter int TW           = 24,
  parameter int FEED_DLY_CYC = `FJSM_FEED_DLY_MS * `FJSM_CYC_PER_MS,
  parameter int FEED_STA_CYC = `FJSM_FEED_STA_MS * `FJSM_CYC_PER_MS,
  parameter int DELV_STA_CYC = `FJSM_DELV_STA_MS * `FJSM_CYC_PER_MS,
  parameter int INIT_DRV_CYC = `FJSM_INIT_DRV_MS * `FJSM_CYC_PER_MS,
  parameter int HOME_CYC     = `FJSM_HOME_MS * `FJSM_CYC_PER_MS,
  parameter int REV_CYC      = `FJSM_REV_MS * `FJSM_CYC_PER_MS,
  parameter int JOG_CYC      = `FJSM_JOG_MS * `FJSM_CYC_PER_MS
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       host_start,        // start-up exchange
  input  wire logic       host_clear,        // leave halt
  input  wire logic       cmd_deliver,       // paper-delivery notice
  input  wire logic       cmd_post_feed,     // feed after staple
  input  wire logic       cmd_staple,        // one staple operation
  input  wire logic       cmd_jog_open,
  input  wire logic       cmd_jog_close,
  input  wire logic       inlet_paper_sensor,
  input  wire logic       delivery_paper_sensor,
  input  wire logic       staple_home_n,
  input  wire logic       staple_ready_n,
  input  wire logic       staple_present,
  output logic            online,
  output logic            halted,
  output logic            feed_motor_on,
  output logic            stapler_motor_cw,
  output logic            stapler_motor_ccw,
  output logic            jogger_motor_cw,
  output logic            jogger_motor_ccw,
  output logic            notify_valid,
  output logic [3:0]      notify_code
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  localparam longint TMAX = (longint'(1) << TW) - 1;
  if (FEED_DLY_CYC < 1 || FEED_DLY_CYC > TMAX ||
      FEED_STA_CYC < 1 || FEED_STA_CYC > TMAX ||
      DELV_STA_CYC < 1 || DELV_STA_CYC > TMAX ||
      INIT_DRV_CYC < 1 || INIT_DRV_CYC > TMAX ||
      HOME_CYC < 1 || HOME_CYC > TMAX ||
      REV_CYC < 1 || REV_CYC > TMAX ||
      JOG_CYC < 1 || JOG_CYC > TMAX) begin : g_bad_cyc
    $error("fjsm_monitor: timeout does not fit the timer");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    fjsm_pkg::fjsm_main_t m;          // start-up / standby / halt
    fjsm_pkg::fjsm_jam_t  j;          // paper path watch
    fjsm_pkg::fjsm_stp_t  s;          // stapler motor phase
    logic                 saw_low;    // home fell during this turn
    logic                 hp_prev;    // home level last cycle
    logic                 ls_prev;    // presence level last cycle
    logic                 prime_on;   // self-priming active
    logic [3:0]           prime_cnt;  // priming ops done
    logic                 low_seen;   // warning given, counting
    logic [4:0]           left;       // staples left after warning
    logic                 jog_open;   // jogger direction
    logic [`FJSM_NOTE_COUNT-1:0] pend; // notices waiting
    logic                 nv;         // notice strobe
    logic [3:0]           nc;         // notice code
  } fjsm_mon_state_t;

  fjsm_mon_state_t r;
  fjsm_mon_state_t next_r;

  // timer controls
  logic          jt_ld, st_ld, gt_ld, stop_all, jt_stop;
  logic [TW-1:0] jt_val, st_val;
  logic          jt_done, st_done, gt_busy;
  logic [`FJSM_NOTE_COUNT-1:0] set, clr;
  logic          op_done;

  // ----------------------------------------------------------------------
  // timers: paper path, stapler, jogger
  // ----------------------------------------------------------------------
  fjsm_timer #(.TW(TW)) u_jam_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (jt_ld && !stop_all),
    .count (jt_val),
    .stop  (jt_stop || stop_all),
    .busy  (),
    .done  (jt_done)
  );

  fjsm_timer #(.TW(TW)) u_stp_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (st_ld && !stop_all),
    .count (st_val),
    .stop  (stop_all || (op_done)),
    .busy  (),
    .done  (st_done)
  );

  fjsm_timer #(.TW(TW)) u_jog_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .load  (gt_ld && !stop_all),
    .count (TW'(JOG_CYC)),
    .stop  (stop_all),
    .busy  (gt_busy),
    .done  ()
  );

  // ----------------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    next_r   = r;
    jt_ld    = 1'b0;
    jt_val   = '0;
    st_ld    = 1'b0;
    st_val   = '0;
    gt_ld    = 1'b0;
    stop_all = 1'b0;
    set      = '0;
    clr      = '0;
    op_done  = 1'b0;
    next_r.nv      = 1'b0;
    next_r.hp_prev = staple_home_n;
    next_r.ls_prev = staple_present;

    // start-up exchange, initial drive, halt recovery
    case (r.m)
      fjsm_pkg::FJSM_M_WAIT: begin
        if (host_start) begin
          next_r.m = fjsm_pkg::FJSM_M_INIT;
          jt_ld    = 1'b1;
          jt_val   = TW'(INIT_DRV_CYC);
        end
      end
      fjsm_pkg::FJSM_M_INIT: begin
        if (inlet_paper_sensor) begin
          set[fjsm_pkg::FJSM_N_RESIDUAL] = 1'b1;
          next_r.m = fjsm_pkg::FJSM_M_HALT;
        end else if (jt_done) begin
          next_r.m = fjsm_pkg::FJSM_M_STBY;
        end
      end
      fjsm_pkg::FJSM_M_HALT: begin
        if (host_clear) begin
          next_r.m = fjsm_pkg::FJSM_M_STBY;
        end
      end
      default: ;
    endcase

    // paper path watch, only acts on host commands in standby
    if (r.m == fjsm_pkg::FJSM_M_STBY) begin
      case (r.j)
        fjsm_pkg::FJSM_J_IDLE: begin
          if (cmd_deliver) begin
            next_r.j = fjsm_pkg::FJSM_J_LEAD;
            jt_ld    = 1'b1;
            jt_val   = TW'(FEED_DLY_CYC);
          end else if (cmd_post_feed) begin
            next_r.j = fjsm_pkg::FJSM_J_DELV;
            jt_ld    = 1'b1;
            jt_val   = TW'(DELV_STA_CYC);
          end
        end
        fjsm_pkg::FJSM_J_LEAD: begin
          if (inlet_paper_sensor) begin
            next_r.j = fjsm_pkg::FJSM_J_TRAIL;
            jt_ld    = 1'b1;
            jt_val   = TW'(FEED_STA_CYC);
          end else if (jt_done) begin
            set[fjsm_pkg::FJSM_N_FEED_DELAY] = 1'b1;
            next_r.m = fjsm_pkg::FJSM_M_HALT;
          end
        end
        fjsm_pkg::FJSM_J_TRAIL: begin
          if (!inlet_paper_sensor) begin
            next_r.j = fjsm_pkg::FJSM_J_IDLE;
          end else if (jt_done) begin
            set[fjsm_pkg::FJSM_N_FEED_STAT] = 1'b1;
            next_r.m = fjsm_pkg::FJSM_M_HALT;
          end
        end
        fjsm_pkg::FJSM_J_DELV: begin
          if (!delivery_paper_sensor) begin
            next_r.j = fjsm_pkg::FJSM_J_IDLE;
          end else if (jt_done) begin
            set[fjsm_pkg::FJSM_N_DELV_STAT] = 1'b1;
            next_r.m = fjsm_pkg::FJSM_M_HALT;
          end
        end
        default: next_r.j = fjsm_pkg::FJSM_J_IDLE;
      endcase

      // stapler: one clockwise turn, reverse once on a stuck cam
      case (r.s)
        fjsm_pkg::FJSM_S_IDLE: begin
          if (r.prime_on && !staple_ready_n) begin
            next_r.prime_on = 1'b0;                 // primed
          end else if ((r.prime_on && staple_ready_n)
                       || cmd_staple) begin
            next_r.s       = fjsm_pkg::FJSM_S_CW;
            next_r.saw_low = 1'b0;
            st_ld          = 1'b1;
            st_val         = TW'(HOME_CYC);
          end
        end
        fjsm_pkg::FJSM_S_CW: begin
          if (!staple_home_n) begin
            next_r.saw_low = 1'b1;
          end
          if (r.saw_low && staple_home_n) begin
            next_r.s = fjsm_pkg::FJSM_S_IDLE;       // full pattern seen
            op_done  = 1'b1;
          end else if (st_done) begin
            if (r.saw_low) begin
              next_r.s = fjsm_pkg::FJSM_S_CCW;
              st_ld    = 1'b1;
              st_val   = TW'(REV_CYC);
            end else begin
              set[fjsm_pkg::FJSM_N_STPL_FAIL] = 1'b1;
              next_r.m = fjsm_pkg::FJSM_M_HALT;
            end
          end
        end
        fjsm_pkg::FJSM_S_CCW: begin
          if (staple_home_n && !r.hp_prev) begin
            set[fjsm_pkg::FJSM_N_STPL_JAM] = 1'b1;
            next_r.s = fjsm_pkg::FJSM_S_IDLE;
            op_done  = 1'b0;
          end else if (st_done) begin
            // cam never freed: treat as stapler failure
            set[fjsm_pkg::FJSM_N_STPL_FAIL] = 1'b1;
            next_r.m = fjsm_pkg::FJSM_M_HALT;
          end
        end
        default: next_r.s = fjsm_pkg::FJSM_S_IDLE;
      endcase

      // jogger, one move per command
      if (!gt_busy) begin
        if (cmd_jog_open) begin
          gt_ld           = 1'b1;
          next_r.jog_open = 1'b1;
        end else if (cmd_jog_close) begin
          gt_ld           = 1'b1;
          next_r.jog_open = 1'b0;
        end
      end
    end

    // a finished staple turn counts for priming and for level
    if (op_done) begin
      if (r.prime_on) begin
        next_r.prime_cnt = r.prime_cnt + 4'h1;
        if (next_r.prime_cnt == `FJSM_PRIME_MAX && staple_ready_n) begin
          set[fjsm_pkg::FJSM_N_PRIME_FAIL] = 1'b1;
          next_r.m        = fjsm_pkg::FJSM_M_HALT;
          next_r.prime_on = 1'b0;
        end
      end
      if (r.low_seen && r.left != 5'h00) begin
        next_r.left = r.left - 5'h01;
        if (r.left == 5'h01) begin
          set[fjsm_pkg::FJSM_N_CART_EMPTY] = 1'b1;
        end
      end
    end

    // cartridge presence edges; these win over the count above
    if (r.m != fjsm_pkg::FJSM_M_WAIT) begin
      if (!r.ls_prev && staple_present) begin
        next_r.prime_on  = 1'b1;
        next_r.prime_cnt = 4'h0;
        next_r.low_seen  = 1'b0;
      end else if (r.ls_prev && !staple_present) begin
        next_r.low_seen = 1'b1;
        next_r.left     = `FJSM_LOW_LEFT;
        set[fjsm_pkg::FJSM_N_LOW_STPL] = 1'b1;
      end
    end

    // entering halt stops every load at once
    if (next_r.m == fjsm_pkg::FJSM_M_HALT &&
        r.m != fjsm_pkg::FJSM_M_HALT) begin
      stop_all        = 1'b1;
      next_r.j        = fjsm_pkg::FJSM_J_IDLE;
      next_r.s        = fjsm_pkg::FJSM_S_IDLE;
      next_r.prime_on = 1'b0;
    end
    jt_stop = (r.j != fjsm_pkg::FJSM_J_IDLE) &&
              (next_r.j == fjsm_pkg::FJSM_J_IDLE);

    // one notice per cycle, lowest code first; a new set wins the clear
    for (int i = `FJSM_NOTE_COUNT - 1; i >= 0; i--) begin
      if (r.pend[i]) begin
        clr       = '0;
        clr[i]    = 1'b1;
        next_r.nc = 4'(i);
      end
    end
    next_r.nv   = (r.pend != '0);
    next_r.pend = (r.pend & ~clr) | set;
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r         <= '0;
      r.hp_prev <= 1'b1;
      r.ls_prev <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------------
  // outputs, decoded from state flops
  // ----------------------------------------------------------------------
  assign online            = (r.m != fjsm_pkg::FJSM_M_WAIT);
  assign halted            = (r.m == fjsm_pkg::FJSM_M_HALT);
  assign feed_motor_on     = (r.m == fjsm_pkg::FJSM_M_INIT) ||
                             (r.m == fjsm_pkg::FJSM_M_STBY &&
                              r.j != fjsm_pkg::FJSM_J_IDLE);
  assign stapler_motor_cw  = (r.s == fjsm_pkg::FJSM_S_CW);
  assign stapler_motor_ccw = (r.s == fjsm_pkg::FJSM_S_CCW);
  assign jogger_motor_cw   = gt_busy && r.jog_open;
  assign jogger_motor_ccw  = gt_busy && !r.jog_open;
  assign notify_valid      = r.nv;
  assign notify_code       = r.nc;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_halt_loads_off: assert property (halted |-> !feed_motor_on &&
    !stapler_motor_cw && !stapler_motor_ccw && !jogger_motor_cw &&
    !jogger_motor_ccw)
    else $error("load driven while halted");
  a_jam_notice: assert property ($rose(halted) |-> ##[0:10] notify_valid)
    else $error("halt without notice");
  a_wait_quiet: assert property (!online |-> !feed_motor_on &&
    !stapler_motor_cw && !jogger_motor_cw && !jogger_motor_ccw)
    else $error("load driven before start-up");
  a_residual_jam: assert property (r.m == fjsm_pkg::FJSM_M_INIT &&
    inlet_paper_sensor |=> halted ##[0:10] notify_valid &&
    notify_code == fjsm_pkg::FJSM_N_RESIDUAL)
    else $error("residual paper not reported");
  a_lead_seen: assert property (r.m == fjsm_pkg::FJSM_M_STBY &&
    r.j == fjsm_pkg::FJSM_J_LEAD && inlet_paper_sensor
    |=> r.j == fjsm_pkg::FJSM_J_TRAIL || halted)
    else $error("leading edge not followed");
  a_prime_start: assert property (online && $rose(staple_present)
    |=> r.prime_on || halted)
    else $error("priming not started");
  a_prime_limit: assert property (r.prime_cnt <= `FJSM_PRIME_MAX)
    else $error("priming count past limit");
  a_low_warn: assert property (online && $fell(staple_present)
    |=> r.left == `FJSM_LOW_LEFT && r.pend[fjsm_pkg::FJSM_N_LOW_STPL])
    else $error("low staple warning missing");
  a_stpl_dir: assert property (!(stapler_motor_cw && stapler_motor_ccw)
    && !(jogger_motor_cw && jogger_motor_ccw))
    else $error("motor driven both ways");
  a_reverse_once: assert property ($rose(stapler_motor_ccw)
    |-> $past(stapler_motor_cw) && !$past(staple_home_n))
    else $error("reverse turn without stuck cam");

  c_staple_op: cover property ($fell(stapler_motor_cw) && !halted);
  c_staple_jam: cover property (notify_valid &&
    notify_code == fjsm_pkg::FJSM_N_STPL_JAM);
  c_sheet_pass: cover property (r.j == fjsm_pkg::FJSM_J_TRAIL
    ##1 r.j == fjsm_pkg::FJSM_J_IDLE);
  c_empty: cover property (notify_valid &&
    notify_code == fjsm_pkg::FJSM_N_CART_EMPTY);

endmodule : fjsm_monitor

`default_nettype wire

/* design/fjsm_timer.sv */
// loadable timeout counter with a one-cycle expiry pulse
`timescale 1ns/1ps
`default_nettype none

module fjsm_timer #(
  parameter int TW = 24
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          load,
  input  wire logic [TW-1:0] count,
  input  wire logic          stop,
  output logic               busy,
  output logic               done
);

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (TW < 2 || TW > 31) begin : g_bad_tw
    $error("fjsm_timer: TW out of range");
  end

  typedef struct packed {
    logic [TW-1:0] cnt;   // cycles left
    logic          run;   // counting
    logic          done;  // expiry pulse
  } fjsm_tmr_state_t;

  fjsm_tmr_state_t r;
  fjsm_tmr_state_t next_r;

  // load wins over stop so a chained phase can restart at once
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (load) begin
      next_r.cnt = count;
      next_r.run = 1'b1;
    end else if (stop) begin
      next_r.run = 1'b0;
    end else if (r.run) begin
      if (r.cnt <= TW'(1)) begin
        next_r.run  = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - TW'(1);
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy = r.run;
  assign done = r.done;

endmodule : fjsm_timer

`default_nettype wire

/* dv/finisher_jam_staple_monitor_test.sv */
// self-checking bench for the jam and staple monitor
`timescale 1ns/1ps
`default_nettype none

module finisher_jam_staple_monitor_test;
  localparam int INIT = 20; // short initial drive
  localparam int JOG  = 10; // short jogger move
  logic       clk, rst_n, inl, dlv, home_n, rdy_n, pres;
  logic [6:0] cmd;      // start clear deliver post staple open close
  logic       cw_q, hit;
  int         cw_n, ccw_n, ops, cam, n_errors, total_checks;
  logic       onl, hlt, feed, scw, sccw, jcw, jccw, nv;
  logic [3:0] nc, last;
  int         notes;

  // ----------------------------------------------------------------------
  // clock, design and host model
  // ----------------------------------------------------------------------
  always #50 clk = ~clk;

  fjsm_monitor #(.FEED_DLY_CYC(20), .FEED_STA_CYC(20), .DELV_STA_CYC(20),
    .INIT_DRV_CYC(INIT), .HOME_CYC(20), .REV_CYC(20), .JOG_CYC(JOG)) dut (
    .clk(clk), .rst_n(rst_n), .host_start(cmd[0]), .host_clear(cmd[1]),
    .cmd_deliver(cmd[2]), .cmd_post_feed(cmd[3]), .cmd_staple(cmd[4]),
    .cmd_jog_open(cmd[5]), .cmd_jog_close(cmd[6]),
    .inlet_paper_sensor(inl), .delivery_paper_sensor(dlv),
    .staple_home_n(home_n), .staple_ready_n(rdy_n), .staple_present(pres),
    .online(onl), .halted(hlt), .feed_motor_on(feed),
    .stapler_motor_cw(scw), .stapler_motor_ccw(sccw),
    .jogger_motor_cw(jcw), .jogger_motor_ccw(jccw),
    .notify_valid(nv), .notify_code(nc));

  fjsm_host_model host (.clk(clk), .rst_n(rst_n), .notify_valid(nv),
    .notify_code(nc), .last_code(last), .n_notes(notes));

  // ----------------------------------------------------------------------
  // stapler cam: 0 normal turn, 1 cam stuck, 2 jammed until reversed
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    #1;
    if (scw === 1'b1 && cw_q !== 1'b1) ops++;
    cw_q  = scw;
    cw_n  = (scw === 1'b1) ? cw_n + 1 : 0;
    ccw_n = (sccw === 1'b1) ? ccw_n + 1 : 0;
    if (cw_n == 3) hit = 1'b1;
    case (cam)
      0: home_n = !(cw_n >= 3 && cw_n < 6);
      1: home_n = 1'b1;
      default: home_n = !(hit && ccw_n < 3);
    endcase
  end

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle command pulse; returns just after the taking edge
  task automatic pulse(input int b);
    tick;
    cmd[b] = 1'b1;
    tick;
    cmd[b] = 1'b0;
  endtask : pulse

  // bounded wait for the next notice, then compare its code
  task automatic wait_note(input logic [3:0] code);
    int i;
    int base;
    base = notes;
    i = 0;
    while (notes == base && i < 600) begin
      tick;
      i++;
    end
    chk({7'h0, notes != base}, 8'h01);
    chk({4'h0, last}, {4'h0, code});
  endtask : wait_note

  task automatic staple_op;
    int i;
    i = 0;
    pulse(4);
    while (scw !== 1'b0 && i < 100) begin
      tick;
      i++;
    end
    chk({7'h0, scw}, 8'h00);
    tick;
  endtask : staple_op

  task automatic reset_start(input logic paper);
    rst_n = 1'b0;
    inl   = paper;
    repeat (6) tick;
    chk({onl, hlt, nv, feed}, 8'h00);
    rst_n = 1'b1;
    tick;
    chk({onl, feed}, 8'h00);
    pulse(0);
    chk({onl, feed}, 8'h03);
  endtask : reset_start

  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0; rst_n = 1'b0; cmd = '0; inl = 0; dlv = 0; home_n = 1'b1;
    rdy_n = 1'b0; pres = 1'b1; cam = 0; hit = 0; ops = 0; cw_q = 0;
    cw_n = 0; ccw_n = 0; n_errors = 0; total_checks = 0;
    // paper left at the inlet during start-up
    reset_start(1'b1);
    wait_note(fjsm_pkg::FJSM_N_RESIDUAL);
    chk({7'h0, hlt}, 8'h01);
    reset_start(1'b0);
    repeat (INIT) tick;
    chk({7'h0, feed}, 8'h01);
    tick;
    chk({hlt, feed}, 8'h00);
    // sheet never arrives
    pulse(2);
    wait_note(fjsm_pkg::FJSM_N_FEED_DELAY);
    chk({hlt, feed}, 8'h02);
    pulse(1);
    // good sheet passes, then a sheet that stalls
    pulse(2);
    repeat (3) tick;
    inl = 1'b1;
    repeat (5) tick;
    inl = 1'b0;
    repeat (3) tick;
    chk({hlt, feed, 2'h0, last}, {4'h0, fjsm_pkg::FJSM_N_FEED_DELAY});
    pulse(2);
    repeat (3) tick;
    inl = 1'b1;
    wait_note(fjsm_pkg::FJSM_N_FEED_STAT);
    inl = 1'b0;
    pulse(1);
    // delivery sensor stays covered after the staple feed
    dlv = 1'b1;
    pulse(3);
    wait_note(fjsm_pkg::FJSM_N_DELV_STAT);
    dlv = 1'b0;
    pulse(1);
    // stuck cam, then a cam freed by the reverse turn
    cam = 1;
    pulse(4);
    wait_note(fjsm_pkg::FJSM_N_STPL_FAIL);
    chk({7'h0, hlt}, 8'h01);
    pulse(1);
    cam = 2;
    hit = 1'b0;
    pulse(4);
    wait_note(fjsm_pkg::FJSM_N_STPL_JAM);
    chk({hlt, sccw}, 8'h00);
    cam = 0;
    // jogger both ways
    pulse(5);
    chk({jcw, jccw}, 8'h02);
    repeat (JOG) tick;
    chk({jcw, jccw}, 8'h00);
    pulse(6);
    chk({jcw, jccw}, 8'h01);
    repeat (JOG + 2) tick;
    // low staples, then exactly twenty more operations
    pres = 1'b0;
    wait_note(fjsm_pkg::FJSM_N_LOW_STPL);
    for (int k = 0; k < 19; k++) staple_op;
    chk({4'h0, last}, {4'h0, fjsm_pkg::FJSM_N_LOW_STPL});
    staple_op;
    wait_note(fjsm_pkg::FJSM_N_CART_EMPTY);
    // new cartridge that never gets ready
    rdy_n = 1'b1;
    ops = 0;
    pres = 1'b1;
    wait_note(fjsm_pkg::FJSM_N_PRIME_FAIL);
    chk(ops[7:0], 8'h0B);
    chk({7'h0, hlt}, 8'h01);
    close_out;
  end

  // ----------------------------------------------------------------------
  // watchdog: the whole run needs well under 5000 cycles
  // ----------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out;
  end
endmodule : finisher_jam_staple_monitor_test

`default_nettype wire

/* dv/fjsm_host_model.sv */
// host controller model that collects notices from the monitor
`timescale 1ns/1ps
`default_nettype none

module fjsm_host_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       notify_valid,
  input  wire logic [3:0] notify_code,
  output var  logic [3:0] last_code,
  output var  int         n_notes
);
  // ----------------------------------------------------------------------
  // notice capture
  // ----------------------------------------------------------------------
  // the code is only read with valid high, since it holds stale values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_code <= 4'hF;
      n_notes   <= 0;
    end else if (notify_valid) begin
      last_code <= notify_code;
      n_notes   <= n_notes + 1;
    end
  end
endmodule : fjsm_host_model

`default_nettype wire

/* pkg/fjsm_params.svh */
// constants for the finisher jam and staple monitor
`ifndef FJSM_PARAMS_SVH
`define FJSM_PARAMS_SVH

// ----------------------------------------------------------------------
// clock and time conversion
// ----------------------------------------------------------------------
`define FJSM_CLK_HZ        10000000
`define FJSM_CYC_PER_MS   (`FJSM_CLK_HZ / 1000)

// ----------------------------------------------------------------------
// timeouts in milliseconds (open values, set at design time)
// ----------------------------------------------------------------------
`define FJSM_FEED_DLY_MS  500
`define FJSM_FEED_STA_MS  1000
`define FJSM_DELV_STA_MS  1000
`define FJSM_INIT_DRV_MS  300
`define FJSM_HOME_MS      200
`define FJSM_REV_MS       200
`define FJSM_JOG_MS       100

// ----------------------------------------------------------------------
// staple and notice counts
// ----------------------------------------------------------------------
`define FJSM_PRIME_MAX    4'hB
`define FJSM_LOW_LEFT     5'h14
`define FJSM_NOTE_COUNT   10

`endif

/* pkg/fjsm_pkg.sv */
// types shared by the finisher jam and staple monitor
`default_nettype none

package fjsm_pkg;

  // ----------------------------------------------------------------------
  // notification codes sent to the host
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    FJSM_N_FEED_DELAY = 4'h0,
    FJSM_N_FEED_STAT  = 4'h1,
    FJSM_N_DELV_STAT  = 4'h2,
    FJSM_N_RESIDUAL   = 4'h3,
    FJSM_N_STPL_FAIL  = 4'h4,
    FJSM_N_STPL_JAM   = 4'h5,
    FJSM_N_PRIME_FAIL = 4'h6,
    FJSM_N_LOW_STPL   = 4'h7,
    FJSM_N_CART_EMPTY = 4'h8,
    FJSM_N_SPARE      = 4'h9
  } fjsm_note_t;

  // ----------------------------------------------------------------------
  // state machines
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FJSM_M_WAIT, FJSM_M_INIT, FJSM_M_STBY, FJSM_M_HALT
  } fjsm_main_t;

  typedef enum logic [1:0] {
    FJSM_J_IDLE, FJSM_J_LEAD, FJSM_J_TRAIL, FJSM_J_DELV
  } fjsm_jam_t;

  typedef enum logic [1:0] {
    FJSM_S_IDLE, FJSM_S_CW, FJSM_S_CCW
  } fjsm_stp_t;

endpackage : fjsm_pkg

`default_nettype wire
